// *** fdh_defines.svh ***
// constant values of the sample flow controller
`ifndef FDH_DEFINES_SVH
`define FDH_DEFINES_SVH
`define FDH_TAPS_DEF 8
`define FDH_DATA_W_DEF 16
`define FDH_COEF_W_DEF 16
`define FDH_CHANNELS_DEF 1
`define FDH_PATHS_DEF 1
`define FDH_COEF_SETS_DEF 1
`define FDH_USE_STROBE_DEF 1
`define FDH_ACC_MAX_W 48
`define FDH_TAP_FIRST 0
`define FDH_CHAN_FIRST 0
`endif

// *** fdh_pkg.sv ***
// types shared by the sample flow controller and its multiply-accumulate lanes
package fdh_pkg;
  typedef enum {ST_IDLE, ST_RUN} fdh_state_e;
  typedef struct packed {
    logic load;
    logic mac;
    logic last;
  } fdh_lane_ctl_s;
endpackage

// *** fdh_mac_lane.sv ***
// one data path: sample history store and serial multiply-accumulate
`timescale 1ns/10ps
`include "fdh_defines.svh"
module fdh_mac_lane #(
  parameter int TAPS = `FDH_TAPS_DEF,
  parameter int DATA_W = `FDH_DATA_W_DEF,
  parameter int COEF_W = `FDH_COEF_W_DEF,
  parameter int CHANNELS = `FDH_CHANNELS_DEF,
  parameter int ACC_W = DATA_W + COEF_W + $clog2(TAPS),
  parameter int CH_W = (CHANNELS > 1) ? $clog2(CHANNELS) : 1,
  parameter int TAP_W = $clog2(TAPS)
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire fdh_pkg::fdh_lane_ctl_s ctl,
  input wire logic [CH_W-1:0] chanSel,
  input wire logic [TAP_W-1:0] tapSel,
  input wire logic signed [COEF_W-1:0] coef,
  input wire logic signed [DATA_W-1:0] sampleIn,
  output logic signed [ACC_W-1:0] result
);
  // history is never reset, so stale samples survive a clear
  logic signed [DATA_W-1:0] hist [CHANNELS][TAPS];
  logic signed [ACC_W-1:0] acc;
  logic signed [DATA_W+COEF_W-1:0] prod;
  logic signed [ACC_W-1:0] sum;

  if (ACC_W < DATA_W + COEF_W) begin : g_acc_chk
    $error("accumulator narrower than one product");
  end

  assign prod = hist[chanSel][tapSel] * coef;
  assign sum = acc + ACC_W'(prod);

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk) begin
    if (ctl.load) begin
      hist[chanSel][0] <= sampleIn;
      for (int i = 1; i < TAPS; i++) begin
        hist[chanSel][i] <= hist[chanSel][i-1];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      acc <= '0;
      result <= '0;
    end else begin
      if (ctl.load) begin
        acc <= '0;
      end else if (ctl.mac) begin
        acc <= sum;
      end
      if (ctl.mac && ctl.last) begin
        result <= sum;
      end
    end
  end
endmodule

// *** fdh_top.sv ***
// sample flow controller: handshake, channel tracking, set select, history count
`timescale 1ns/10ps
`include "fdh_defines.svh"
module fdh_top #(
  parameter int TAPS = `FDH_TAPS_DEF,
  parameter int DATA_W = `FDH_DATA_W_DEF,
  parameter int COEF_W = `FDH_COEF_W_DEF,
  parameter int CHANNELS = `FDH_CHANNELS_DEF,
  parameter int PATHS = `FDH_PATHS_DEF,
  parameter int COEF_SETS = `FDH_COEF_SETS_DEF,
  parameter bit USE_STROBE = `FDH_USE_STROBE_DEF,
  parameter int ACC_W = DATA_W + COEF_W + $clog2(TAPS),
  parameter int CH_W = (CHANNELS > 1) ? $clog2(CHANNELS) : 1,
  parameter int SET_W = (COEF_SETS > 1) ? $clog2(COEF_SETS) : 1,
  parameter int TAP_W = $clog2(TAPS)
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic sync_clear,
  input wire logic clkEn,
  input wire logic sample_strobe_in,
  input wire logic [PATHS-1:0][DATA_W-1:0] sampleIn,
  input wire logic [SET_W-1:0] coef_set_select,
  input wire logic [COEF_SETS-1:0][TAPS-1:0][COEF_W-1:0] coefTable,
  output logic accept_ready_out,
  output logic resultValid,
  output logic fullHistValid,
  output logic [PATHS-1:0][ACC_W-1:0] resultOut,
  output logic [CH_W-1:0] chanIn,
  output logic [CH_W-1:0] chanOut
);
  localparam int HIST_NEED = TAPS * CHANNELS;
  localparam int HCNT_W = $clog2(HIST_NEED + 1);

  ////////////////////////////////////////////////////////////////////////////
  // elaboration checks
  generate
    if (ACC_W > `FDH_ACC_MAX_W) begin : g_acc_chk
      $error("accumulator wider than allowed");
    end
    if (TAPS < 2 || CHANNELS < 1 || PATHS < 1 || COEF_SETS < 1) begin : g_par_chk
      $error("unsupported filter parameters");
    end
    if (COEF_SETS > (1 << SET_W) || CHANNELS > (1 << CH_W)) begin : g_w_chk
      $error("select width too narrow");
    end
    if (TAP_W < 1 || TAPS > (1 << TAP_W)) begin : g_tap_chk
      $error("tap index too narrow");
    end
    if (ACC_W < DATA_W + COEF_W) begin : g_prod_chk
      $error("accumulator narrower than one product");
    end
    if (DATA_W < 1 || COEF_W < 1) begin : g_dw_chk
      $error("data and coefficient widths must be positive");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // control state
  fdh_pkg::fdh_state_e state;
  fdh_pkg::fdh_state_e next_state;
  logic [TAP_W-1:0] tap;
  logic [TAP_W-1:0] next_tap;
  logic [CH_W-1:0] jobChan;
  logic [SET_W-1:0] jobSet;
  logic jobFull;
  logic [HCNT_W-1:0] histCnt;
  logic [HCNT_W-1:0] next_histCnt;
  logic [CH_W-1:0] next_chanIn;
  logic validPulse;
  logic fullPulse;

  wire clearCtl = sys_rst | sync_clear;
  wire isIdle = (state == fdh_pkg::ST_IDLE);
  wire isRun = (state == fdh_pkg::ST_RUN);
  wire isLast = (tap == TAP_W'(TAPS - 1));
  // low in reset too, so no sample is taken into a cleared job
  wire readyNow = isIdle & clkEn & ~clearCtl;
  // strobeless build takes the input on every ready cycle
  wire strobeOk = USE_STROBE ? sample_strobe_in : 1'h1;
  wire accept = readyNow & strobeOk;
  wire stepNow = isRun & clkEn & ~sync_clear;
  // final tap step: the result leaves on the next edge
  wire finishNow = stepNow & isLast;
  wire histSat = (histCnt == HCNT_W'(HIST_NEED));
  wire histFullNext = (next_histCnt == HCNT_W'(HIST_NEED));
  // a new sample goes to its own channel, later steps to the job's
  wire [CH_W-1:0] laneChan = accept ? chanIn : jobChan;

  assign accept_ready_out = readyNow;

  ////////////////////////////////////////////////////////////////////////////
  // next-state decode
  always_comb begin
    next_state = state;
    next_tap = tap;
    case (state)
      fdh_pkg::ST_IDLE: begin
        if (accept) begin
          next_state = fdh_pkg::ST_RUN;
          next_tap = TAP_W'(`FDH_TAP_FIRST);
        end
      end
      fdh_pkg::ST_RUN: begin
        // no strobe can stop a running job; only freeze or clear
        if (isLast) begin
          next_state = fdh_pkg::ST_IDLE;
        end else begin
          next_tap = tap + TAP_W'(1);
        end
      end
      default: begin
        next_state = fdh_pkg::ST_IDLE;
      end
    endcase
  end

  // saturating count of accepted samples
  assign next_histCnt = (accept && !histSat) ? histCnt + HCNT_W'(1) : histCnt;
  // channels arrive in order on the shared input
  assign next_chanIn = (chanIn == CH_W'(CHANNELS - 1)) ?
                       CH_W'(`FDH_CHAN_FIRST) : chanIn + CH_W'(1);

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk) begin
    if (clearCtl) begin
      state <= fdh_pkg::ST_IDLE;
      tap <= '0;
    end else if (clkEn) begin
      state <= next_state;
      tap <= next_tap;
    end
  end

  always_ff @(posedge core_clk) begin
    if (clearCtl) begin
      histCnt <= '0;
      chanIn <= CH_W'(`FDH_CHAN_FIRST);
      jobChan <= '0;
      jobSet <= '0;
      jobFull <= 1'h0;
    end else if (accept) begin
      histCnt <= next_histCnt;
      chanIn <= next_chanIn;
      jobChan <= chanIn;
      jobSet <= coef_set_select;
      jobFull <= histFullNext;
    end
  end

  always_ff @(posedge core_clk) begin
    if (clearCtl) begin
      validPulse <= 1'h0;
      fullPulse <= 1'h0;
      chanOut <= '0;
    end else if (clkEn) begin
      validPulse <= finishNow;
      fullPulse <= finishNow & jobFull;
      if (finishNow) begin
        chanOut <= jobChan;
      end
    end
  end

  // held pulses are masked while frozen
  assign resultValid = validPulse & clkEn;
  assign fullHistValid = fullPulse & clkEn;

  ////////////////////////////////////////////////////////////////////////////
  // lanes: one per parallel path, sharing this control
  fdh_pkg::fdh_lane_ctl_s laneCtl;
  wire logic [COEF_W-1:0] coefNow = coefTable[jobSet][tap];

  assign laneCtl.load = accept;
  assign laneCtl.mac = stepNow;
  assign laneCtl.last = isLast;

  genvar p;
  generate
    for (p = 0; p < PATHS; p++) begin : g_lane
      fdh_mac_lane #(
        .TAPS(TAPS),
        .DATA_W(DATA_W),
        .COEF_W(COEF_W),
        .CHANNELS(CHANNELS),
        .ACC_W(ACC_W),
        .CH_W(CH_W),
        .TAP_W(TAP_W)
      ) u_lane (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .ctl(laneCtl),
        .chanSel(laneChan),
        .tapSel(tap),
        .coef(coefNow),
        .sampleIn(sampleIn[p]),
        .result(resultOut[p])
      );
    end
  endgenerate
endmodule

// *** fdh_source.sv ***
// upstream sample source model: holds each sample until the filter takes it
`timescale 1ns/10ps
module fdh_source (
  input wire logic core_clk,
  input wire logic accept_ready_out,
  output logic sample_strobe_in,
  output logic [15:0] sampleIn,
  output logic coef_set_select
);
  logic took = 1'b0;
  initial begin
    sample_strobe_in = 1'b0;
    sampleIn = 16'h0000;
    coef_set_select = 1'b0;
  end
  always @(posedge core_clk) took <= accept_ready_out && sample_strobe_in;
  task automatic send(input logic [15:0] d, input logic s);
    @(negedge core_clk);
    sample_strobe_in = 1'b1;
    sampleIn = d;
    coef_set_select = s;
    for (int i = 0; i < 200 && !took; i++) @(negedge core_clk);
    sample_strobe_in = 1'b0;
    sampleIn = ~d;
  endtask
endmodule

// *** fdh_top_assertions.sv ***
// concurrent checks of handshake, result timing and channel tracking
`timescale 1ns/10ps
module fdh_top_checker #(parameter int TAPS = 8, parameter int CHANNELS = 1,
  parameter int CH_W = 1, parameter bit USE_STROBE = 1'h1) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic sync_clear,
  input wire logic clkEn,
  input wire logic sample_strobe_in,
  input wire logic accept_ready_out,
  input wire logic resultValid,
  input wire logic fullHistValid,
  input wire logic [CH_W-1:0] chanIn,
  input wire logic [CH_W-1:0] chanOut
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic [7:0] cnt;
  logic [7:0] hist;
  logic [CH_W-1:0] takeCh;
  // a strobeless build takes a sample on every ready cycle
  wire take = accept_ready_out && (sample_strobe_in || !USE_STROBE);
  // enabled cycles since the last take, and saturating take count
  always_ff @(posedge core_clk) begin
    if (sys_rst || sync_clear) begin
      cnt <= 8'h00;
      hist <= 8'h00;
    end else if (take) begin
      cnt <= 8'h01;
      takeCh <= chanIn;
      if (hist < TAPS * CHANNELS) hist <= hist + 8'h01;
    end else if (clkEn && cnt != 8'h00 && cnt <= TAPS + 1) begin
      cnt <= cnt + 8'h01;
    end
  end
  sequence s_take;
    take;
  endsequence
  property p_ready;
    accept_ready_out == (clkEn && !sync_clear && (cnt == 8'h00 || cnt > TAPS));
  endproperty
  a_ready: assert property (p_ready) else $error("ready wrong");
  property p_valid;
    resultValid == (clkEn && cnt == TAPS + 1);
  endproperty
  a_valid: assert property (p_valid) else $error("valid timing wrong");
  property p_full;
    fullHistValid == (resultValid && hist >= TAPS * CHANNELS);
  endproperty
  a_full: assert property (p_full) else $error("full flag wrong");
  property p_clear;
    sync_clear |=> !resultValid && chanIn == '0 && chanOut == '0;
  endproperty
  a_clear: assert property (p_clear) else $error("clear missed");
  property p_chan_in;
    s_take |=> chanIn == CH_W'((32'(takeCh) + 1) % CHANNELS);
  endproperty
  a_chan_in: assert property (p_chan_in) else $error("chanIn step wrong");
  property p_chan_hold;
    !take && !sync_clear |=> $stable(chanIn);
  endproperty
  a_chan_hold: assert property (p_chan_hold) else $error("chanIn moved");
  property p_chan_out;
    resultValid |-> chanOut == takeCh;
  endproperty
  a_chan_out: assert property (p_chan_out) else $error("chanOut wrong");
  property p_freeze;
    !clkEn |-> !resultValid && !fullHistValid && !accept_ready_out;
  endproperty
  a_freeze: assert property (p_freeze) else $error("moved while frozen");
endmodule
bind fdh_top fdh_top_checker #(.TAPS(TAPS), .CHANNELS(CHANNELS), .CH_W(CH_W),
  .USE_STROBE(USE_STROBE)) u_chk (
  .core_clk, .sys_rst, .sync_clear, .clkEn, .sample_strobe_in, .accept_ready_out,
  .resultValid, .fullHistValid, .chanIn, .chanOut);

// *** tb.sv ***
// bench: history fill, enable stalls, clear with stale history
`timescale 1ns/10ps
module tb;
  typedef struct {logic [33:0] val; logic ch; logic full; bit known;} fdh_exp_s;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic sync_clear = 1'b0;
  logic clkEn = 1'b1;
  logic sample_strobe_in, coef_set_select, accept_ready_out, resultValid, fullHistValid;
  logic [15:0] sampleIn;
  logic [1:0][3:0][15:0] coefTable;
  logic [33:0] resultOut;
  logic chanIn, chanOut;
  localparam logic [15:0] NS_SAMPLE = 16'h0007;
  logic nsReady, nsValid, nsFull;
  logic [33:0] nsResult;
  logic chNext = 1'b0;
  logic signed [15:0] hist[2][4];
  fdh_exp_s expQ[$];
  fdh_exp_s r;
  int failures = 0, num_checks = 0, taken = 0, got[2] = '{0, 0};
  always #20 core_clk = ~core_clk;
  fdh_top #(.TAPS(4), .CHANNELS(2), .COEF_SETS(2)) u_dut (.core_clk, .sys_rst, .sync_clear,
    .clkEn, .sample_strobe_in, .sampleIn, .coef_set_select, .coefTable, .accept_ready_out,
    .resultValid, .fullHistValid, .resultOut, .chanIn, .chanOut);
  fdh_source u_src (.core_clk, .accept_ready_out, .sample_strobe_in, .sampleIn,
    .coef_set_select);
  // strobeless build fed a held sample, sharing clock, reset, clear and enable
  fdh_top #(.TAPS(4), .USE_STROBE(1'h0)) u_dut_ns (.core_clk, .sys_rst, .sync_clear, .clkEn,
    .sample_strobe_in(1'h0), .sampleIn(NS_SAMPLE), .coef_set_select(1'h0),
    .coefTable(coefTable[0]), .accept_ready_out(nsReady), .resultValid(nsValid),
    .fullHistValid(nsFull), .resultOut(nsResult), .chanIn(), .chanOut());
  task automatic check(input string name, input logic [33:0] seen, input logic [33:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic test_done();
    if (failures == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic send(input logic [15:0] d, input logic s);
    fdh_exp_s e;
    u_src.send(d, s);
    for (int k = 3; k > 0; k--) hist[chNext][k] = hist[chNext][k - 1];
    hist[chNext][0] = d;
    got[chNext]++;
    if (taken < 8) taken++;
    e.val = '0;
    for (int k = 0; k < 4; k++) e.val += 34'($signed(coefTable[s][k]) * hist[chNext][k]);
    e.ch = chNext;
    e.full = taken >= 8;
    e.known = got[chNext] >= 4;
    expQ.push_back(e);
    chNext = ~chNext;
  endtask
  always @(posedge core_clk) begin
    if (resultValid === 1'b1) begin
      if (expQ.size() == 0) check("spare result", 1, 0);
      else begin
        r = expQ.pop_front();
        check("chanOut", chanOut, r.ch);
        check("fullHistValid", fullHistValid, r.full);
        if (r.known) check("resultOut", resultOut, r.val);
      end
    end
  end
  task automatic drain();
    for (int i = 0; i < 100 && expQ.size() > 0; i++) @(negedge core_clk);
    check("results missing", expQ.size(), 0);
  endtask
  task automatic t_fill();
    for (int i = 0; i < 10; i++) send(16'h0010 + 16'(i), i >= 8);
    drain();
  endtask
  task automatic t_stall();
    for (int w = 0; w < 5; w += 4) begin
      send(16'h0123, 1'b1);
      repeat (w) @(negedge core_clk);
      clkEn = 1'b0;
      repeat (3) @(negedge core_clk);
      check("ready frozen", accept_ready_out, 0);
      clkEn = 1'b1;
      drain();
    end
  endtask
  task automatic t_nostrobe();
    int rdy = 0;
    int vld = 0;
    logic [33:0] exp = '0;
    for (int k = 0; k < 4; k++) exp += 34'($signed(coefTable[0][k]) * $signed(NS_SAMPLE));
    for (int i = 0; i < 20; i++) begin
      @(negedge core_clk);
      if (nsReady === 1'h1) rdy++;
      if (nsValid === 1'h1) begin
        vld++;
        check("ns resultOut", nsResult, exp);
        check("ns fullHistValid", nsFull, 1);
      end
    end
    check("ns ready count", rdy, 4);
    check("ns result count", vld, 4);
  endtask
  task automatic t_clear();
    send(16'h0F00, 1'b0);
    sync_clear = 1'b1;
    clkEn = 1'b0;
    @(negedge core_clk);
    check("chanIn cleared", chanIn, 0);
    clkEn = 1'b1;
    @(negedge core_clk);
    check("ready in clear", accept_ready_out, 0);
    sync_clear = 1'b0;
    expQ.delete();
    chNext = 1'b0;
    taken = 0;
    send(16'h0042, 1'b0);
    drain();
  endtask
  initial begin
    for (int s = 0; s < 2; s++)
      for (int k = 0; k < 4; k++) coefTable[s][k] = 16'(s * 4 + k + 1);
    repeat (2) @(negedge core_clk);
    sys_rst = 1'b0;
    t_fill();
    t_nostrobe();
    t_stall();
    t_clear();
    test_done();
  end
  initial begin
    #100000;
    failures++;
    test_done();
  end
endmodule
